// ===== bench/ast_sig_model.sv
// far-side model: channel samples and edge trigger lines
`timescale 1ns/100ps
module ast_sig_model (
  // clock
  input wire logic clk_in,
  // levels the bench wants on the lines
  input wire logic [31:0] ch_want_in,
  input wire logic [12:0] ln_want_in,
  // lines into the unit
  output logic [31:0] chan_out,
  output ast_pkg::ast_trig_lines_s lines_out
);
  // lines move just after an edge, so each sample clock sees one stable value
  always_ff @(posedge clk_in) begin
    chan_out <= ch_want_in;
    lines_out <= ln_want_in;
  end
endmodule : ast_sig_model

// ===== bench/ast_start_trigger_asserts.sv
// port checker for the start trigger unit
`timescale 1ns/100ps
module ast_start_trigger_asserts (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire ast_pkg::ast_bus_req_s bus_in,
  input wire logic [31:0] rdata_out,
  // acquisition control
  input wire logic start_trig_out,
  input wire logic running_out,
  input wire logic drv_en_out,
  input wire logic resources_held_out
);
  logic cmd_wr;
  logic fres_wr;
  logic close_wr;
  logic arm_wr;
  // command decode; full reset outranks close in one write
  assign cmd_wr = bus_in.wr && bus_in.addr == ast_pkg::REG_CMD;
  assign fres_wr = cmd_wr && bus_in.wdata[ast_pkg::CMD_FULL_RESET_BIT];
  assign close_wr = cmd_wr && bus_in.wdata[ast_pkg::CMD_CLOSE_BIT] && !fres_wr;
  assign arm_wr = cmd_wr && bus_in.wdata[ast_pkg::CMD_ARM_BIT];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  trig_pulse_a: assert property (start_trig_out |=> !start_trig_out)
    else $error("start pulse longer than one cycle");
  trig_runs_a: assert property (start_trig_out |-> running_out && drv_en_out)
    else $error("start without running drivers");
  run_cause_a: assert property ($rose(running_out) |-> start_trig_out)
    else $error("running without start");
  rd_window_a: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
    else $error("read data outside its cycle");
  close_stop_a: assert property (close_wr |=> !running_out && !resources_held_out)
    else $error("close left operation or resources");
  close_drive_a: assert property (close_wr |=> $stable(drv_en_out))
    else $error("close changed driver enable");
  full_reset_a: assert property (fres_wr |=> !drv_en_out && !running_out)
    else $error("full reset left drivers on");
  drv_cause_a: assert property ($rose(drv_en_out) |-> $past(arm_wr))
    else $error("drivers on without arm");
  cover property (start_trig_out);
  cover property (close_wr && running_out);
  cover property (fres_wr && drv_en_out);
endmodule : ast_start_trigger_asserts

bind ast_start_trigger ast_start_trigger_asserts u_chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .bus_in(bus_in),
  .rdata_out(rdata_out),
  .start_trig_out(start_trig_out),
  .running_out(running_out),
  .drv_en_out(drv_en_out),
  .resources_held_out(resources_held_out)
);

// ===== bench/ast_start_trigger_tb.sv
// self-checking bench for the start trigger unit
`timescale 1ns/100ps
module ast_start_trigger_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ast_pkg::ast_bus_req_s bus = '0;
  logic [31:0] rdata;
  logic [31:0] rd_q;
  logic [3:0] pt;
  logic [31:0] ch_want = 32'h0;
  logic [12:0] ln_want = 13'h0;
  logic [31:0] chan;
  ast_pkg::ast_trig_lines_s lines;
  logic trig, run, drv, held;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // pattern table: {code, mode 0 match 1 mismatch 2 generation, before, after, fires}
  logic [7:0] tbl [14] = '{8'h20, 8'h23, 8'h46, 8'h45, 8'h63, 8'h64, 8'h85,
    8'h82, 8'ha0, 8'ha5, 8'h2e, 8'h2d, 8'h01, 8'h32};

  always #25 sys_clk = ~sys_clk;

  ast_start_trigger #(.NUM_CH(32)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .bus_in(bus), .rdata_out(rdata),
    .chan_in(chan), .trig_lines_in(lines), .start_trig_out(trig),
    .running_out(run), .drv_en_out(drv), .resources_held_out(held));
  ast_sig_model sig (.clk_in(sys_clk), .ch_want_in(ch_want), .ln_want_in(ln_want),
    .chan_out(chan), .lines_out(lines));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one strobe cycle, then an idle cycle in which read data stand
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    bus <= '0;
    @(negedge sys_clk);
    rd_q = rdata;
    pt = {trig, drv, held, run};
    @(posedge sys_clk);
  endtask : xfer

  task automatic fres();
    xfer(1'b1, ast_pkg::REG_CMD, 32'h10);
  endtask : fres

  // counts start pulses over n cycles
  task automatic watch(input int n, output int f);
    f = 0;
    repeat (n) begin
      @(negedge sys_clk);
      f += int'(trig === 1'b1);
    end
    @(posedge sys_clk);
  endtask : watch

  function automatic logic [12:0] lbit(input int s);
    return s < 4 ? 13'h1 << (9 + s) : s < 12 ? 13'h1 << (s - 3) : 13'h1;
  endfunction : lbit

  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // hang guard, well above the roughly seven hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    int f;
    logic [7:0] e;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, ast_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", ast_pkg::CTRL_RESET, rd_q);
    xfer(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    // every source, both edges; others and the wrong edge must not fire
    for (int s = 0; s < 13; s++) begin
      for (int fl = 0; fl < 2; fl++) begin
        ln_want <= {13{fl[0]}} ^ lbit(s);
        fres();
        xfer(1'b1, ast_pkg::REG_EDGE, 32'(s + 16 * fl));
        xfer(1'b1, ast_pkg::REG_CTRL, 32'h9);
        xfer(1'b1, ast_pkg::REG_CMD, 32'h1);
        ln_want <= ln_want ^ 13'h1fff;
        watch(4, f);
        chk("edge quiet", 32'h0, f);
        ln_want <= ln_want ^ lbit(s);
        watch(4, f);
        chk("edge fire", 32'h1, f);
      end
    end
    // slot 0 listed as channel 7, the other channels opposite
    foreach (tbl[i]) begin
      e = tbl[i];
      ch_want <= {32{~e[2]}} ^ 32'h80;
      fres();
      xfer(1'b1, ast_pkg::REG_ORDER_BASE, 32'h7);
      xfer(1'b1, ast_pkg::REG_PAT_BASE, 32'(e[7:5]));
      xfer(1'b1, ast_pkg::REG_CTRL, 32'h102 | {~e[4], e[3], 2'h0});
      xfer(1'b1, ast_pkg::REG_CMD, 32'h1);
      ch_want[7] <= e[1];
      watch(6, f);
      chk("pattern", 32'(e[0]), 32'(f != 0));
    end
    // word variant: only channel 7 selected, channels 0 to 6 unlike the word
    ch_want <= 32'h7f;
    fres();
    xfer(1'b1, ast_pkg::REG_WORD_VAL, 32'h80);
    xfer(1'b1, ast_pkg::REG_CTRL, 32'h11a);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h1);
    watch(4, f);
    chk("word early", 32'h0, f);
    ch_want[7] <= 1'b1;
    watch(4, f);
    chk("word fire", 32'h1, f);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h4);
    chk("abort pins", 32'h6, pt);
    // two slots naming one channel
    xfer(1'b1, ast_pkg::REG_ORDER_BASE + 8'h4, 32'h7);
    xfer(1'b1, ast_pkg::REG_CTRL, 32'h20a);
    xfer(1'b0, ast_pkg::REG_STATUS, 32'h0);
    chk("cfg error", 32'h1, rd_q[2]);
    xfer(1'b1, ast_pkg::REG_ORDER_BASE + 8'h4, 32'h3);
    xfer(1'b0, ast_pkg::REG_STATUS, 32'h0);
    chk("cfg clean", 32'h0, rd_q[2]);
    // software start, then close while running
    fres();
    xfer(1'b1, ast_pkg::REG_CTRL, 32'hb);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h1);
    watch(4, f);
    chk("sw early", 32'h0, f);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h2);
    chk("sw fire", 32'h1, pt[3]);
    watch(4, f);
    chk("sw once", 32'h0, f);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h8);
    xfer(1'b0, ast_pkg::REG_STATUS, 32'h0);
    chk("close status", 32'hc, rd_q[4:1]);
    chk("close pins", 32'h4, pt);
    xfer(1'b1, ast_pkg::REG_CMD, 32'h3);
    watch(4, f);
    chk("closed start", 32'h0, f);
    fres();
    chk("reset pins", 32'h0, pt);
    complete_run();
  end
endmodule : ast_start_trigger_tb

// ===== hw/ast_pkg.sv
// package for the acquisition start trigger unit: register map, fields, encodings
package ast_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EDGE = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_WORD_VAL = 8'h10;
  localparam logic [7:0] REG_PAT_BASE = 8'h40;
  localparam logic [7:0] REG_ORDER_BASE = 8'h80;
  // control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_MISMATCH_BIT = 2;
  localparam int CTRL_ACQ_MODE_BIT = 3;
  localparam int CTRL_WORD_BIT = 4;
  localparam int CTRL_COUNT_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  // edge register fields
  localparam int EDGE_SEL_LSB = 0;
  localparam int EDGE_FALL_BIT = 4;
  // command bits
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_SW_TRIG_BIT = 1;
  localparam int CMD_ABORT_BIT = 2;
  localparam int CMD_CLOSE_BIT = 3;
  localparam int CMD_FULL_RESET_BIT = 4;
  // status bits
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_TRIG_BIT = 1;
  localparam int STAT_CFG_ERR_BIT = 2;
  localparam int STAT_CLOSED_BIT = 3;
  localparam int STAT_DRV_EN_BIT = 4;
  // edge source numbering
  localparam logic [3:0] SRC_FUNC_FIRST = 4'h0;
  localparam logic [3:0] SRC_BKP_FIRST = 4'h4;
  localparam logic [3:0] SRC_STAR = 4'hc;
  localparam int NUM_FUNC_IN = 4;
  localparam int NUM_BKP_LINES = 8;

  typedef enum logic [1:0] {SRC_NONE, SRC_EDGE, SRC_PATTERN, SRC_SOFTWARE} ast_src_e;
  typedef enum logic [2:0] {
    COND_IGNORE = 3'h0,
    COND_ONE = 3'h1,
    COND_ZERO = 3'h2,
    COND_RISE = 3'h3,
    COND_FALL = 3'h4,
    COND_EITHER = 3'h5
  } ast_cond_e;

  // register port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ast_bus_req_s;

  // external edge trigger lines
  typedef struct packed {
    logic [NUM_FUNC_IN-1:0] programmable_function_input;
    logic [NUM_BKP_LINES-1:0] backplane_trigger_line;
    logic star_trigger_line;
  } ast_trig_lines_s;
endpackage : ast_pkg

// ===== hw/ast_start_trigger.sv
// acquisition start trigger unit: edge, pattern and software start with close handling
// Functional notes
// - each pattern slot takes a level code: ignore, need one, need zero
// - each pattern slot may also need a rising, falling or either edge
// - match polarity: trigger when every non-ignored slot condition holds
// - mismatch polarity: trigger when the pattern does not hold
// - slot k applies to the k-th listed channel via the order table
// - flag an error when slot count differs from selected channel count
// - word variant: channels outside the selection are don't-care
// - word variant encodes only high or low levels per channel
// - pattern start only works in acquisition mode, never in generation
// - edge start detects rising or falling as configured
// - edge source: four function inputs, eight backplane lines, star line
// - software start fires on a trigger-assert command write
// - close while running aborts first, then releases resources
// - close keeps drivers enabled at their post-abort levels
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module ast_start_trigger #(
  parameter int NUM_CH = 32
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire ast_pkg::ast_bus_req_s bus_in,
  output logic [31:0] rdata_out,
  // signals under test and trigger lines
  input wire logic [NUM_CH-1:0] chan_in,
  input wire ast_pkg::ast_trig_lines_s trig_lines_in,
  // acquisition control
  output logic start_trig_out,
  output logic running_out,
  output logic drv_en_out,
  output logic resources_held_out
);
  localparam int CW = $clog2(NUM_CH);
  localparam int NW = $clog2(NUM_CH + 1);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_CLOSED} ast_state_e;

  // configuration registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] edge_q, edge_d;
  logic [NUM_CH-1:0] word_val_q, word_val_d;
  logic [2:0] pat_q [NUM_CH];
  logic [2:0] pat_d [NUM_CH];
  logic [CW-1:0] order_q [NUM_CH];
  logic [CW-1:0] order_d [NUM_CH];
  // run state
  ast_state_e state_q, state_d;
  logic [NUM_CH-1:0] prev_q, prev_d;
  logic line_prev_q, line_prev_d;
  logic trig_q, trig_d;
  logic run_q, run_d;
  // held and driver enable are apart so close can drop one and keep the other
  logic drv_en_q, drv_en_d;
  logic held_q, held_d;
  logic [31:0] rdata_q, rdata_d;
  // combinational helpers
  logic [NUM_CH-1:0] sel_mask;
  logic [NUM_CH-1:0] word_mask;
  logic pat_ok, word_ok, edge_hit, cfg_err;
  logic [NW-1:0] sel_count;
  logic line_now;

  // one slot condition against current and previous channel sample
  function automatic logic cond_ok(input logic [2:0] c, input logic cur, input logic prv);
    unique case (c)
      ast_pkg::COND_IGNORE: cond_ok = 1'b1;
      ast_pkg::COND_ONE: cond_ok = cur;
      ast_pkg::COND_ZERO: cond_ok = ~cur;
      ast_pkg::COND_RISE: cond_ok = cur & ~prv;
      ast_pkg::COND_FALL: cond_ok = ~cur & prv;
      ast_pkg::COND_EITHER: cond_ok = cur ^ prv;
      default: cond_ok = 1'b1; // unused codes act as ignore
    endcase
  endfunction : cond_ok

  // pattern slot window, one word per slot
  function automatic logic in_pat_win(input logic [7:0] a);
    in_pat_win = (a >= ast_pkg::REG_PAT_BASE) && (a < ast_pkg::REG_ORDER_BASE);
  endfunction : in_pat_win

  // channel order window, same slot spacing as the pattern window
  function automatic logic in_order_win(input logic [7:0] a);
    in_order_win = (a[7:6] == ast_pkg::REG_ORDER_BASE[7:6]);
  endfunction : in_order_win

  // only sixteen slots are reachable through each window
  function automatic logic slot_ok(input logic [7:0] a);
    slot_ok = int'(a[5:2]) < NUM_CH;
  endfunction : slot_ok

  // pattern evaluation over listed channels; edge codes look one sample back,
  // so the first armed cycle compares against the sample taken while idle
  always_comb begin
    logic [CW-1:0] ch;
    logic [NW-1:0] slots;
    ch = '0;
    slots = ctrl_q[ast_pkg::CTRL_COUNT_LSB +: NW];
    pat_ok = 1'b1;
    sel_mask = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      ch = order_q[k];
      if (k < int'(slots)) begin
        sel_mask[ch] = 1'b1;
        if (!cond_ok(pat_q[k], chan_in[ch], prev_q[ch])) begin
          pat_ok = 1'b0;
        end
      end
    end
    sel_count = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      sel_count = sel_count + NW'(sel_mask[k]);
    end
    // duplicate channels in the list shrink the selected set below the slot count
    cfg_err = (sel_count != slots) || (slots > NW'(NUM_CH));
    // the word variant builds its mask from the same slot list
    word_mask = sel_mask;
  end

  // word-wide variant: level compare, unselected bits masked off
  // slot codes play no part here, so edge conditions cannot be asked for
  assign word_ok = ((chan_in ^ word_val_q) & word_mask) == '0;

  // edge source mux and edge detector
  // limitation: rewriting the source while armed may see one false edge,
  // since the held sample still belongs to the old line for a cycle
  always_comb begin
    logic [3:0] s;
    s = edge_q[ast_pkg::EDGE_SEL_LSB +: 4];
    if (s < ast_pkg::SRC_BKP_FIRST) begin
      line_now = trig_lines_in.programmable_function_input[s[1:0]];
    end else if (s < ast_pkg::SRC_STAR) begin
      line_now = trig_lines_in.backplane_trigger_line[3'(s - ast_pkg::SRC_BKP_FIRST)];
    end else begin
      line_now = trig_lines_in.star_trigger_line;
    end
    if (edge_q[ast_pkg::EDGE_FALL_BIT]) begin
      edge_hit = line_prev_q & ~line_now;
    end else begin
      edge_hit = ~line_prev_q & line_now;
    end
  end

  // next state for control, registers and trigger
  always_comb begin
    logic match;
    ast_pkg::ast_src_e src;
    logic [7:0] a;
    ctrl_d = ctrl_q;
    edge_d = edge_q;
    word_val_d = word_val_q;
    pat_d = pat_q;
    order_d = order_q;
    state_d = state_q;
    // history moves every cycle, armed or not, so arming never sees stale data
    prev_d = chan_in;
    line_prev_d = line_now;
    trig_d = 1'b0;
    drv_en_d = drv_en_q;
    held_d = held_q;
    rdata_d = '0;
    a = bus_in.addr;
    src = ast_pkg::ast_src_e'(ctrl_q[ast_pkg::CTRL_SRC_LSB +: 2]);
    match = ctrl_q[ast_pkg::CTRL_WORD_BIT] ? word_ok : pat_ok;
    // mismatch inverts the whole result, edge codes included
    if (ctrl_q[ast_pkg::CTRL_MISMATCH_BIT]) begin
      match = ~match;
    end
    // armed: wait for the selected start condition
    // source none starts at once, the plain free-run case
    if (state_q == ST_ARMED) begin
      unique case (src)
        ast_pkg::SRC_NONE: trig_d = 1'b1;
        ast_pkg::SRC_EDGE: trig_d = edge_hit;
        // bad config or generation mode never fires a pattern start
        ast_pkg::SRC_PATTERN: trig_d = match & ~cfg_err & ctrl_q[ast_pkg::CTRL_ACQ_MODE_BIT];
        ast_pkg::SRC_SOFTWARE: trig_d = 1'b0;
      endcase
      if (trig_d) begin
        state_d = ST_RUN;
      end
    end
    // register writes
    // later command bits win the next state: full reset, close, abort, trigger, arm
    if (bus_in.wr) begin
      if (a == ast_pkg::REG_CTRL) begin
        ctrl_d = bus_in.wdata;
      end else if (a == ast_pkg::REG_EDGE) begin
        edge_d = bus_in.wdata;
      end else if (a == ast_pkg::REG_WORD_VAL) begin
        word_val_d = bus_in.wdata[NUM_CH-1:0];
      end else if (a == ast_pkg::REG_CMD) begin
        // arming reserves resources and turns the drivers on
        if (bus_in.wdata[ast_pkg::CMD_ARM_BIT] && state_q == ST_IDLE) begin
          state_d = ST_ARMED;
          held_d = 1'b1;
          drv_en_d = 1'b1;
        end
        if (bus_in.wdata[ast_pkg::CMD_SW_TRIG_BIT] && state_q == ST_ARMED
            && src == ast_pkg::SRC_SOFTWARE) begin
          trig_d = 1'b1;
          state_d = ST_RUN;
        end
        if (bus_in.wdata[ast_pkg::CMD_ABORT_BIT] && state_q != ST_CLOSED) begin
          state_d = ST_IDLE; // drivers stay as they were
          trig_d = 1'b0;
        end
        if (bus_in.wdata[ast_pkg::CMD_CLOSE_BIT]) begin
          state_d = ST_CLOSED;
          trig_d = 1'b0;
          held_d = 1'b0;
          // no tristate on close, and an arm in the same write cannot switch drivers on
          drv_en_d = drv_en_q;
        end
        // full reset is the only command that tristates the drivers; rst_in does too
        if (bus_in.wdata[ast_pkg::CMD_FULL_RESET_BIT]) begin
          state_d = ST_IDLE;
          drv_en_d = 1'b0;
          held_d = 1'b0;
        end
      end else if (in_pat_win(a)) begin
        if (slot_ok(a)) begin
          pat_d[a[5:2]] = bus_in.wdata[2:0];
        end
      end else if (in_order_win(a)) begin
        if (slot_ok(a)) begin
          order_d[a[5:2]] = bus_in.wdata[CW-1:0];
        end
      end
    end
    // running gets its own flop so the port is not a decode of the state
    run_d = (state_d == ST_RUN);
    // register reads, data in the next cycle
    if (bus_in.rd) begin
      if (a == ast_pkg::REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (a == ast_pkg::REG_EDGE) begin
        rdata_d = edge_q;
      end else if (a == ast_pkg::REG_WORD_VAL) begin
        rdata_d = 32'(word_val_q);
      end else if (a == ast_pkg::REG_STATUS) begin
        // live view; nothing here clears on read
        rdata_d[ast_pkg::STAT_ARMED_BIT] = (state_q == ST_ARMED);
        rdata_d[ast_pkg::STAT_TRIG_BIT] = (state_q == ST_RUN);
        rdata_d[ast_pkg::STAT_CFG_ERR_BIT] = cfg_err;
        rdata_d[ast_pkg::STAT_CLOSED_BIT] = (state_q == ST_CLOSED);
        rdata_d[ast_pkg::STAT_DRV_EN_BIT] = drv_en_q;
      end else if (in_pat_win(a)) begin
        if (slot_ok(a)) begin
          rdata_d = 32'(pat_q[a[5:2]]);
        end
      end else if (in_order_win(a)) begin
        if (slot_ok(a)) begin
          rdata_d = 32'(order_q[a[5:2]]);
        end
      end
    end
  end

  // registers only; every port below reads straight from this bank
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_q <= ast_pkg::CTRL_RESET;
      edge_q <= '0;
      word_val_q <= '0;
      // order table starts as identity, so slot k watches channel k
      for (int k = 0; k < NUM_CH; k++) begin
        pat_q[k] <= '0;
        order_q[k] <= CW'(k);
      end
      state_q <= ST_IDLE;
      prev_q <= '0;
      line_prev_q <= '0;
      trig_q <= 1'b0;
      run_q <= 1'b0;
      drv_en_q <= 1'b0;
      held_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      edge_q <= edge_d;
      word_val_q <= word_val_d;
      pat_q <= pat_d;
      order_q <= order_d;
      state_q <= state_d;
      prev_q <= prev_d;
      line_prev_q <= line_prev_d;
      trig_q <= trig_d;
      run_q <= run_d;
      drv_en_q <= drv_en_d;
      held_q <= held_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign rdata_out = rdata_q;
  assign start_trig_out = trig_q;
  assign running_out = run_q;
  assign drv_en_out = drv_en_q;
  assign resources_held_out = held_q;
endmodule : ast_start_trigger
